// ==== hw/usb_rx_fifo_status_pop.sv ====
// receive FIFO status queue with peek and pop registers and pop interrupts
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module usb_rx_fifo_status_pop
  import usb_rx_status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic host_mode,
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [3:0] push_status,
  input wire logic [1:0] push_pid,
  input wire logic [10:0] push_packet_byte_count,
  input wire logic [3:0] push_num,
  output logic rx_fifo_nonempty_flag,
  output logic irq
);

  typedef struct packed {
    logic [QUEUE_DEPTH-1:0][ENTRY_W-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [16:0] words_used;
    logic [15:0] rx_fifo_depth;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic nonempty_en;
    logic [31:0] rdata;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [ENTRY_W-1:0] top;
  logic [3:0] top_code;
  logic pop_fire;
  logic push_fire;
  logic [16:0] push_need;
  logic [EV_W-1:0] pop_ev;

  // words an entry takes in the shared FIFO: the status word plus its data payload
  function automatic logic [16:0] words_for(input logic [3:0] code, input logic [10:0] bc, input logic host);
    logic carries;
    carries = (code == PK_DATA) || (!host && code == PK_SETUP_DATA);
    words_for = 17'd1;
    if (carries) begin
      // a full 2047-byte packet needs 512 data words, so the quotient keeps all ten bits
      words_for = 17'd1 + 17'((12'(bc) + 12'd3) >> 2);
    end
  endfunction

  // interrupts follow the pop, so software sees them in queue order
  function automatic logic [EV_W-1:0] event_for(input logic [3:0] code, input logic host);
    event_for = '0;
    if (host) begin
      event_for[EV_IN_DONE] = (code == PK_XFER_DONE);
      event_for[EV_TOGGLE_ERR] = (code == PK_TOGGLE_ERR);
      event_for[EV_HALTED] = (code == PK_HALTED);
    end else begin
      event_for[EV_GONAK] = (code == PK_GONAK);
      event_for[EV_OUT_DONE] = (code == PK_XFER_DONE);
      event_for[EV_SETUP_DONE] = (code == PK_SETUP_DONE);
    end
  endfunction

  assign top = s_q.mem[s_q.rd_ptr];
  assign top_code = top[PKST_LSB +: 4];
  assign push_need = words_for(push_status, push_packet_byte_count, host_mode);
  // depth register bounds occupancy; the queue also bounds entries
  assign push_ready = (s_q.count != CNT_W'(QUEUE_DEPTH)) &&
                      ((s_q.words_used + push_need) <= {1'b0, s_q.rx_fifo_depth});
  assign push_fire = push_valid && push_ready;
  assign pop_fire = reg_rd && (reg_addr == OFF_POP) && (s_q.count != '0);
  assign pop_ev = pop_fire ? event_for(top_code, host_mode) : '0;

  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFF_PEEK: s_d.rdata = (s_q.count != '0) ? {11'h000, top} : STATUS_RESET;
        OFF_POP: s_d.rdata = (s_q.count != '0) ? {11'h000, top} : STATUS_RESET;
        OFF_LEN: s_d.rdata = {16'h0000, s_q.rx_fifo_depth};
        OFF_IRQ_STAT: s_d.rdata = {26'h0, s_q.irq_stat};
        OFF_IRQ_MASK: s_d.rdata = {26'h0, s_q.irq_mask};
        OFF_CTRL: s_d.rdata = {27'h0, s_q.nonempty_en, 4'h0};
        default: s_d.rdata = '0;
      endcase
    end
    if (pop_fire) begin
      s_d.rd_ptr = s_q.rd_ptr + 1'b1;
    end
    if (push_fire) begin
      s_d.mem[s_q.wr_ptr] = {push_status, push_pid, push_packet_byte_count, push_num};
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    end
    s_d.count = s_q.count + CNT_W'(push_fire) - CNT_W'(pop_fire);
    s_d.words_used = s_q.words_used + (push_fire ? push_need : 17'd0)
                   - (pop_fire ? words_for(top_code, top[BCNT_LSB +: 11], host_mode) : 17'd0);
    if (reg_wr) begin
      case (reg_addr)
        OFF_LEN: s_d.rx_fifo_depth = reg_wdata[15:0];
        OFF_IRQ_MASK: s_d.irq_mask = reg_wdata[EV_W-1:0];
        OFF_CTRL: s_d.nonempty_en = reg_wdata[CTRL_NE_EN_BIT];
        default: s_d.rx_fifo_depth = s_q.rx_fifo_depth;
      endcase
    end
    // a new event beats a write-one clear in the same cycle
    s_d.irq_stat = (s_q.irq_stat & ~((reg_wr && reg_addr == OFF_IRQ_STAT) ? reg_wdata[EV_W-1:0] : '0)) | pop_ev;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.rx_fifo_depth <= RX_FIFO_DEPTH_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign rx_fifo_nonempty_flag = (s_q.count != '0);
  assign irq = |(s_q.irq_stat & s_q.irq_mask) || (rx_fifo_nonempty_flag && s_q.nonempty_en);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence peek_read_s;
    reg_rd && reg_addr == OFF_PEEK && s_q.count != '0 && !push_fire;
  endsequence

  sequence pop_read_s;
    reg_rd && reg_addr == OFF_POP && s_q.count != '0 && !push_fire;
  endsequence

  peek_keeps_entry_a: assert property (peek_read_s |=>
    s_q.count == $past(s_q.count) && reg_rdata == {11'h000, $past(top)})
    else $error("peek read changed queue or returned wrong entry");

  pop_removes_entry_a: assert property (pop_read_s |=>
    s_q.count == $past(s_q.count) - 1'b1 && reg_rdata == {11'h000, $past(top)})
    else $error("pop read did not remove top entry");

  entry_layout_a: assert property (push_fire && s_q.count == '0 && !reg_rd |=>
    top == {$past(push_status), $past(push_pid), $past(push_packet_byte_count), $past(push_num)})
    else $error("entry fields out of place");

  gonak_irq_a: assert property (pop_read_s and (!host_mode && top_code == PK_GONAK) |=>
    s_q.irq_stat[EV_GONAK])
    else $error("global OUT NAK pop raised no event");

  out_done_irq_a: assert property (pop_read_s and (!host_mode && top_code == PK_XFER_DONE) |=>
    s_q.irq_stat[EV_OUT_DONE] && !s_q.irq_stat[EV_IN_DONE])
    else $error("OUT done pop raised wrong event");

  setup_done_irq_a: assert property (pop_read_s and (!host_mode && top_code == PK_SETUP_DONE) |=>
    s_q.irq_stat[EV_SETUP_DONE])
    else $error("SETUP done pop raised no event");

  host_halt_irq_a: assert property (pop_read_s and (host_mode && top_code == PK_HALTED) |=>
    s_q.irq_stat[EV_HALTED] ##1 s_q.irq_stat[EV_HALTED] || $past(reg_wr))
    else $error("channel halted pop raised no event");

  depth_limit_a: assert property (push_fire |->
    s_q.words_used + push_need <= {1'b0, s_q.rx_fifo_depth})
    else $error("push accepted beyond programmed depth");

  len_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0) rst |=>
    s_q.rx_fifo_depth == RX_FIFO_DEPTH_RESET && s_q.count == '0)
    else $error("length register reset value wrong");

  nonempty_irq_a: assert property (rx_fifo_nonempty_flag && s_q.nonempty_en |-> irq)
    else $error("enabled non-empty flag gave no interrupt");

  empty_pop_a: assert property (reg_rd && reg_addr == OFF_POP && s_q.count == '0 && !push_fire |=>
    s_q.count == '0 && reg_rdata == STATUS_RESET)
    else $error("pop of empty queue had an effect");

  host_in_irq_a: assert property (pop_read_s and (host_mode && top_code == PK_XFER_DONE) |=>
    s_q.irq_stat[EV_IN_DONE])
    else $error("IN done pop raised no event");

  host_toggle_irq_a: assert property (pop_read_s and (host_mode && top_code == PK_TOGGLE_ERR) |=>
    s_q.irq_stat[EV_TOGGLE_ERR])
    else $error("toggle error pop raised no event");

  event_wins_a: assert property (pop_fire && pop_ev != '0 |=>
    (s_q.irq_stat & $past(pop_ev)) == $past(pop_ev))
    else $error("clear beat a new event");

  reserved_zero_a: assert property (reg_rdata[31:21] == 11'h000)
    else $error("reserved read bits not zero");

  len_write_a: assert property (reg_wr && reg_addr == OFF_LEN |=>
    s_q.rx_fifo_depth == $past(reg_wdata[15:0]))
    else $error("depth write not stored");

endmodule // usb_rx_fifo_status_pop

// ==== hw/usb_rx_status_pkg.sv ====
// constants, offsets and field layout for the receive status pop block
// Operation
// - peek read returns top entry, keeps it
// - pop read returns top entry, removes it
// - status 20:17, byte count 14:4, number 3:0
// - device status 0001 global OUT NAK, interrupts
// - device status 0010 OUT data, data follow
// - device status 0011 OUT done, interrupts
// - device status 0100 SETUP done, interrupts
// - device status 0110 SETUP data received
// - data PID 00 is DATA0, 10 DATA1
// - byte count gives received packet bytes
// - device low four bits give endpoint
// - depth field sizes FIFO in words, 1..1024; the code stores any 16-bit value written, unchecked
// - length register resets to 0x00000200
// - status registers reset to zero, reserved zero
// - separate enable gates non-empty interrupt
package usb_rx_status_pkg;
  localparam logic [7:0] OFF_PEEK = 8'h1C;
  localparam logic [7:0] OFF_POP = 8'h20;
  localparam logic [7:0] OFF_LEN = 8'h24;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFF_CTRL = 8'h48;
  localparam int ENTRY_W = 21;
  localparam int PKST_LSB = 17;
  localparam int PID_LSB = 15;
  localparam int BCNT_LSB = 4;
  localparam int NUM_LSB = 0;
  localparam int QUEUE_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [15:0] RX_FIFO_DEPTH_RESET = 16'h0200;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam int CTRL_NE_EN_BIT = 4;
  localparam logic [3:0] PK_GONAK = 4'h1;
  localparam logic [3:0] PK_DATA = 4'h2;
  localparam logic [3:0] PK_XFER_DONE = 4'h3;
  localparam logic [3:0] PK_SETUP_DONE = 4'h4;
  localparam logic [3:0] PK_TOGGLE_ERR = 4'h5;
  localparam logic [3:0] PK_SETUP_DATA = 4'h6;
  localparam logic [3:0] PK_HALTED = 4'h7;
  localparam logic [1:0] PID_DATA0 = 2'h0;
  localparam logic [1:0] PID_DATA1 = 2'h2;
  localparam int EV_W = 6;
  localparam int EV_GONAK = 0;
  localparam int EV_OUT_DONE = 1;
  localparam int EV_SETUP_DONE = 2;
  localparam int EV_IN_DONE = 3;
  localparam int EV_TOGGLE_ERR = 4;
  localparam int EV_HALTED = 5;
endpackage

// ==== tb/rx_link_source.sv ====
// link-side source that offers one status entry at a time
`timescale 1ns/1ps
module rx_link_source (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic send,
  input wire logic [20:0] entry,
  input wire logic push_ready,
  output logic push_valid,
  output logic [20:0] push_entry
);
  // after a handover the fields flip so stale values never look valid
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      push_valid <= 1'b0;
      push_entry <= 21'h1FFFFF;
    end else if (push_valid && push_ready) begin
      push_valid <= 1'b0;
      push_entry <= ~push_entry;
    end else if (send && !push_valid) begin
      push_valid <= 1'b1;
      push_entry <= entry;
    end
  end
endmodule // rx_link_source

// ==== tb/tb_usb_rx_fifo_status_pop.sv ====
// self-checking bench for the receive status peek and pop block
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_usb_rx_fifo_status_pop;
  import usb_rx_status_pkg::*;
  logic ref_clk, rst, reg_wr, reg_rd, host_mode, push_valid, push_ready, ne, irq, send;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [20:0] entry, pe;
  int err_total, check_count, cyc;
  usb_rx_fifo_status_pop u_usb_rx_fifo_status_pop (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_mode(host_mode),
    .push_valid(push_valid), .push_ready(push_ready), .push_status(pe[20:17]), .push_pid(pe[16:15]),
    .push_packet_byte_count(pe[14:4]), .push_num(pe[3:0]), .rx_fifo_nonempty_flag(ne), .irq(irq));
  rx_link_source u_rx_link_source (.ref_clk(ref_clk), .rst(rst), .send(send), .entry(entry),
    .push_ready(push_ready), .push_valid(push_valid), .push_entry(pe));
  // full-word accesses only; results are looked at mid-cycle once settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic push(input logic [20:0] e);
    int n;
    @(posedge ref_clk);
    entry <= e;
    send <= 1'b1;
    @(posedge ref_clk);
    send <= 1'b0;
    n = 0;
    @(negedge ref_clk);
    while (push_valid && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic reset_values;
    rd(OFF_LEN); `CHK("len", 32'h0000_0200, d)
    rd(OFF_PEEK); `CHK("peek", 32'h0000_0000, d)
    rd(OFF_POP); `CHK("pop", 32'h0000_0000, d)
    rd(8'h30); `CHK("unmapped", 32'h0000_0000, d)
  endtask
  // one entry per status code, event bit -1 for codes that raise nothing
  task automatic one(input logic m, input logic [3:0] c, input int ev);
    logic [20:0] e;
    e = {c, c[0] ? PID_DATA1 : PID_DATA0, 7'h00, c, c + 4'h8};
    @(posedge ref_clk);
    host_mode <= m;
    push(e); `CHK("ne", 1'b1, ne)
    rd(OFF_PEEK); rd(OFF_PEEK); `CHK("peek", {11'h000, e}, d)
    rd(OFF_POP); `CHK("pop", {11'h000, e}, d)
    rd(OFF_IRQ_STAT); `CHK("stat", ev < 0 ? 32'h0 : 32'h1 << ev, d)
    `CHK("irq", ev >= 0, irq)
    wr(OFF_IRQ_STAT, 32'h0000_003F); `CHK("irq clr", 1'b0, irq)
  endtask
  task automatic order_and_depth;
    push(21'h0ABCD1); push(21'h044442); `CHK("ready", 1'b1, push_ready)
    rd(OFF_POP); `CHK("first", 32'h000A_BCD1, d)
    rd(OFF_PEEK); `CHK("next", 32'h0004_4442, d)
    rd(OFF_POP); `CHK("ne low", 1'b0, ne)
    wr(OFF_IRQ_STAT, 32'h0000_003F); `CHK("toggle clr", 1'b0, irq)
    wr(OFF_CTRL, 32'h0000_0010); rd(OFF_CTRL); `CHK("ctrl rw", 32'h0000_0010, d)
    push(21'h000011); `CHK("ne irq", 1'b1, irq)
    rd(OFF_POP); `CHK("ne irq off", 1'b0, irq)
    wr(OFF_IRQ_MASK, 32'h0); rd(OFF_IRQ_MASK); `CHK("mask rw", 32'h0, d)
    // masked event still latches in status but keeps irq low
    @(posedge ref_clk);
    host_mode <= 1'b0;
    push(21'h020000); rd(OFF_POP); rd(OFF_IRQ_STAT); `CHK("masked stat", 32'h0000_0001, d)
    `CHK("masked irq", 1'b0, irq)
    wr(OFF_IRQ_STAT, 32'h0000_003F);
    wr(OFF_LEN, 32'h0000_0001); rd(OFF_LEN); `CHK("len rw", 32'h0000_0001, d)
    push(21'h040040);
    `CHK("ready full", 1'b0, push_ready)
    wr(OFF_LEN, 32'h0000_0200); repeat (2) @(posedge ref_clk); @(negedge ref_clk); `CHK("ne", 1'b1, ne)
    rd(OFF_POP); `CHK("data", 32'h0004_0040, d)
  endtask
  task automatic summarize;
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ceiling is far above the few hundred cycles the scenarios need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin err_total++; summarize(); end
  end
  initial begin
    {rst, reg_wr, reg_rd, host_mode, send, reg_addr, reg_wdata, entry} = '0;
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    reset_values();
    wr(OFF_IRQ_MASK, 32'h0000_003F);
    one(1'b0, PK_GONAK, EV_GONAK); one(1'b0, PK_DATA, -1); one(1'b0, PK_XFER_DONE, EV_OUT_DONE);
    one(1'b0, PK_SETUP_DONE, EV_SETUP_DONE); one(1'b0, PK_SETUP_DATA, -1); one(1'b1, PK_DATA, -1);
    one(1'b1, PK_XFER_DONE, EV_IN_DONE); one(1'b1, PK_TOGGLE_ERR, EV_TOGGLE_ERR); one(1'b1, PK_HALTED, EV_HALTED);
    order_and_depth();
    summarize();
  end
endmodule // tb_usb_rx_fifo_status_pop
